// [logic/flash_prot_pkg.sv]
// constants and register map of the flash protection and key controller
// Summary of operation
// - top 2 kB of array 0 always refused
// - erase whole pages only, program needs erased bits
// - boot select low at reset selects download
// - bit 31 of array 0 blocks debug reads
// - other array 0 bits write-protect 2 kB groups
// - write protection applies to every access source
// - all array 1 bits are write-protect groups
// - volatile protection immediate, keyless, lost on reset
// - persistent protection effective after save and reset
// - saved key must match for later changes
// - mass erase restores all-ones key
// - permanent key refuses any further key save
// - only mass erase removes permanent protection
// - save command, poll status, then reset
// - status done and fail clear on read
package flash_prot_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_ADDR     = 8'h04;
    localparam logic [7:0] OFS_WORD     = 8'h08;
    localparam logic [7:0] OFS_CMD      = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_VOL0     = 8'h14;
    localparam logic [7:0] OFS_PERS0    = 8'h18;
    localparam logic [7:0] OFS_VOL1     = 8'h1c;
    localparam logic [7:0] OFS_PERS1    = 8'h20;
    localparam logic [7:0] OFS_IRQ_STA  = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    // mode register fields
    localparam int MODE_WR_EN  = 3;
    localparam int MODE_IRQ_EN = 4;
    localparam int MODE_GUARD  = 5;
    localparam int MODE_KEY_EN = 6;
    // status register fields
    localparam int STA_DONE = 0;
    localparam int STA_FAIL = 1;
    localparam int STA_BUSY = 2;
    localparam int STA_INT  = 3;
    // protection layout: 2 kB groups, 512 byte pages
    localparam int GRP_LSB  = 11;
    localparam int PAGE_LSB = 9;
    localparam logic [4:0] FW_GROUP = 5'h1f;
    localparam int READ_LOCK_BIT = 31;
    // commands
    localparam logic [7:0] CMD_PROGRAM    = 8'h02;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h06;
    localparam logic [7:0] CMD_SAVE_KEY   = 8'h0c;
    // keys and reset values (protection bits are active low)
    localparam logic [31:0] KEY_ERASED = 32'hffffffff;
    localparam logic [31:0] KEY_PERM   = 32'hdeaddead;
    localparam logic [31:0] PROT_RST   = 32'hffffffff;
    localparam logic [31:0] ZERO32     = 32'h00000000;
    // access sources
    localparam logic [1:0] SRC_CORE     = 2'h0;
    localparam logic [1:0] SRC_SERIAL   = 2'h1;
    localparam logic [1:0] SRC_DEBUG    = 2'h2;
    localparam logic [1:0] SRC_PARALLEL = 2'h3;
    // array operation kinds
    localparam logic [1:0] OP_PROGRAM = 2'h1;
    localparam logic [1:0] OP_PAGE    = 2'h2;
    localparam logic [1:0] OP_MASS    = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CHECK  = 2'b01,
        ST_FINISH = 2'b11
    } cmd_state_t;
endpackage

// [logic/flash_protection_key_control.sv]
// flash protection, key store and command checker with apb registers
//
// Our own choices: register access over APB and the register addresses.
module flash_protection_key_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        boot_select_pin,
    output logic             download_mode,
    input  wire logic        acc_req,
    input  wire logic        acc_write,
    input  wire logic [1:0]  acc_src,
    input  wire logic        acc_array,
    input  wire logic [15:0] acc_addr,
    output logic             acc_grant,
    output logic             acc_deny,
    input  wire logic [7:0]  flash_cur_byte,
    output logic             arr_op,
    output logic      [1:0]  arr_kind,
    output logic             arr_sel,
    output logic      [15:0] arr_addr,
    output logic      [7:0]  arr_data
);
    logic [7:0]  mode_r;
    logic [16:0] addr_r;
    logic [15:0] word_r;
    logic [31:0] vol0_r, vol1_r, pers0_r, pers1_r;
    logic [31:0] act0_r, act1_r;
    logic [31:0] nv_key_r, nv_pend0_r, nv_pend1_r;
    logic [2:0]  irq_sta_r, irq_mask_r;
    logic        sta_done_r, sta_fail_r, sta_int_r;
    logic        init_r, res_ok_r;
    logic [7:0]  cmd_r;
    flash_prot_pkg::cmd_state_t st_r;
    logic [31:0] rd_mux, eff0, eff1;
    logic        hit, xfer, wr, rd, rd_sta;
    logic        cmd_ok, do_save, do_wipe, acc_ok;
    logic        set_done, set_fail;
    logic [31:0] key_in;

    // effective protection: a zero in either register protects
    assign eff0 = vol0_r & act0_r;
    assign eff1 = vol1_r & act1_r;

    // write permission for one array address, firmware group never writable
    function automatic logic wr_ok(input logic arr, input logic [15:0] a);
        logic [4:0] g;
        g = a[15:flash_prot_pkg::GRP_LSB];
        if (arr) begin
            wr_ok = eff1[g];
        end else begin
            wr_ok = (g != flash_prot_pkg::FW_GROUP) && eff0[g];
        end
    endfunction

    // apb decode; one wait state so that read data comes from a flop
    assign xfer   = psel & penable & pready;
    assign wr     = xfer & pwrite & hit;
    assign rd     = xfer & ~pwrite & hit;
    assign rd_sta = rd & (paddr == flash_prot_pkg::OFS_STATUS);

    always_comb begin
        hit    = 1'b1;
        rd_mux = flash_prot_pkg::ZERO32;
        unique case (paddr)
            flash_prot_pkg::OFS_MODE:     rd_mux[7:0] = mode_r;
            flash_prot_pkg::OFS_ADDR:     rd_mux[16:0] = addr_r;
            flash_prot_pkg::OFS_WORD:     rd_mux[15:0] = word_r;
            flash_prot_pkg::OFS_CMD:      rd_mux[7:0] = cmd_r;
            flash_prot_pkg::OFS_STATUS:   rd_mux[3:0] = {sta_int_r,
                                              st_r != flash_prot_pkg::ST_IDLE,
                                              sta_fail_r, sta_done_r};
            flash_prot_pkg::OFS_VOL0:     rd_mux = vol0_r;
            flash_prot_pkg::OFS_PERS0:    rd_mux = pers0_r;
            flash_prot_pkg::OFS_VOL1:     rd_mux = vol1_r;
            flash_prot_pkg::OFS_PERS1:    rd_mux = pers1_r;
            flash_prot_pkg::OFS_IRQ_STA:  rd_mux[2:0] = irq_sta_r;
            flash_prot_pkg::OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_r;
            default:                      hit = 1'b0;
        endcase
    end

    // apb answer, ready and data land together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= flash_prot_pkg::ZERO32;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata  <= rd_mux;
        end
    end

    // software written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r     <= 8'h00;
            addr_r     <= 17'h00000;
            word_r     <= 16'h0000;
            vol0_r     <= flash_prot_pkg::PROT_RST;
            vol1_r     <= flash_prot_pkg::PROT_RST;
            pers0_r    <= flash_prot_pkg::PROT_RST;
            pers1_r    <= flash_prot_pkg::PROT_RST;
            irq_mask_r <= 3'h0;
        end else if (wr) begin
            unique case (paddr)
                flash_prot_pkg::OFS_MODE:     mode_r <= pwdata[7:0];
                flash_prot_pkg::OFS_ADDR:     addr_r <= pwdata[16:0];
                flash_prot_pkg::OFS_WORD:     word_r <= pwdata[15:0];
                flash_prot_pkg::OFS_VOL0:     vol0_r <= pwdata;
                flash_prot_pkg::OFS_VOL1:     vol1_r <= pwdata;
                flash_prot_pkg::OFS_PERS0:    pers0_r <= pwdata;
                flash_prot_pkg::OFS_PERS1:    pers1_r <= pwdata;
                flash_prot_pkg::OFS_IRQ_MASK: irq_mask_r <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // key check; erased key accepts any first key
    assign key_in  = {addr_r[15:0], word_r};
    assign do_save = (st_r == flash_prot_pkg::ST_CHECK)
                     && (cmd_r == flash_prot_pkg::CMD_SAVE_KEY)
                     && mode_r[flash_prot_pkg::MODE_WR_EN]
                     && mode_r[flash_prot_pkg::MODE_KEY_EN]
                     && !mode_r[flash_prot_pkg::MODE_GUARD]
                     && (nv_key_r != flash_prot_pkg::KEY_PERM)
                     && ((nv_key_r == flash_prot_pkg::KEY_ERASED)
                         || (nv_key_r == key_in));
    // mass erase works even under the permanent key
    assign do_wipe = (st_r == flash_prot_pkg::ST_CHECK)
                     && (cmd_r == flash_prot_pkg::CMD_MASS_ERASE)
                     && mode_r[flash_prot_pkg::MODE_WR_EN];

    // command result, judged in the check state
    always_comb begin
        cmd_ok = 1'b0;
        unique case (cmd_r)
            // program may only clear bits already erased
            flash_prot_pkg::CMD_PROGRAM:
                cmd_ok = mode_r[flash_prot_pkg::MODE_WR_EN]
                         && wr_ok(addr_r[16], addr_r[15:0])
                         && ((~flash_cur_byte & word_r[7:0]) == 8'h00);
            flash_prot_pkg::CMD_PAGE_ERASE:
                cmd_ok = mode_r[flash_prot_pkg::MODE_WR_EN]
                         && wr_ok(addr_r[16], addr_r[15:0]);
            flash_prot_pkg::CMD_MASS_ERASE: cmd_ok = do_wipe;
            flash_prot_pkg::CMD_SAVE_KEY:   cmd_ok = do_save;
            default:                        cmd_ok = 1'b0;
        endcase
    end

    // command sequencer; a command written while busy is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= flash_prot_pkg::ST_IDLE;
            cmd_r    <= 8'h00;
            res_ok_r <= 1'b0;
            arr_op   <= 1'b0;
            arr_kind <= 2'h0;
            arr_sel  <= 1'b0;
            arr_addr <= 16'h0000;
            arr_data <= 8'h00;
        end else begin
            arr_op <= 1'b0;
            unique case (st_r)
                flash_prot_pkg::ST_IDLE: begin
                    if (wr && paddr == flash_prot_pkg::OFS_CMD
                        && pwdata[7:0] != 8'h00) begin
                        cmd_r    <= pwdata[7:0];
                        arr_sel  <= addr_r[16];
                        arr_addr <= addr_r[15:0];
                        arr_data <= word_r[7:0];
                        st_r     <= flash_prot_pkg::ST_CHECK;
                    end
                end
                flash_prot_pkg::ST_CHECK: begin
                    res_ok_r <= cmd_ok;
                    st_r     <= flash_prot_pkg::ST_FINISH;
                    if (cmd_ok && cmd_r == flash_prot_pkg::CMD_PROGRAM) begin
                        arr_op   <= 1'b1;
                        arr_kind <= flash_prot_pkg::OP_PROGRAM;
                    end
                    // erase is rounded to the page
                    if (cmd_ok && cmd_r == flash_prot_pkg::CMD_PAGE_ERASE) begin
                        arr_op   <= 1'b1;
                        arr_kind <= flash_prot_pkg::OP_PAGE;
                        arr_addr <= {addr_r[15:flash_prot_pkg::PAGE_LSB],
                                     9'h000};
                    end
                    if (cmd_ok && cmd_r == flash_prot_pkg::CMD_MASS_ERASE) begin
                        arr_op   <= 1'b1;
                        arr_kind <= flash_prot_pkg::OP_MASS;
                        arr_addr <= 16'h0000;
                    end
                end
                flash_prot_pkg::ST_FINISH: st_r <= flash_prot_pkg::ST_IDLE;
                default: st_r <= flash_prot_pkg::ST_IDLE;
            endcase
        end
    end

    // completion reported in status for polling
    assign set_done = (st_r == flash_prot_pkg::ST_FINISH) & res_ok_r;
    assign set_fail = (st_r == flash_prot_pkg::ST_FINISH) & ~res_ok_r;

    // read clears done and fail; a same-cycle set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sta_done_r <= 1'b0;
            sta_fail_r <= 1'b0;
            sta_int_r  <= 1'b0;
        end else begin
            sta_done_r <= set_done | (sta_done_r & ~rd_sta);
            sta_fail_r <= set_fail | (sta_fail_r & ~rd_sta);
            sta_int_r  <= (set_done & mode_r[flash_prot_pkg::MODE_IRQ_EN])
                          | (sta_int_r & ~rd_sta);
        end
    end

    // sticky interrupt causes, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sta_r <= 3'h0;
            irq       <= 1'b0;
        end else begin
            irq_sta_r <= {acc_deny, set_fail, set_done}
                         | (irq_sta_r & ~((wr && paddr ==
                            flash_prot_pkg::OFS_IRQ_STA) ? pwdata[2:0]
                                                         : 3'h0));
            irq       <= |(irq_sta_r & irq_mask_r);
        end
    end

    // non-volatile key and pending store, kept across system reset
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            nv_key_r   <= flash_prot_pkg::KEY_ERASED;
            nv_pend0_r <= flash_prot_pkg::PROT_RST;
            nv_pend1_r <= flash_prot_pkg::PROT_RST;
        end else if (do_wipe) begin
            nv_key_r   <= flash_prot_pkg::KEY_ERASED;
            nv_pend0_r <= flash_prot_pkg::PROT_RST;
            nv_pend1_r <= flash_prot_pkg::PROT_RST;
        end else if (do_save) begin
            // key stored along with the pattern
            nv_key_r   <= key_in;
            nv_pend0_r <= pers0_r;
            nv_pend1_r <= pers1_r;
        end
    end

    // active persistent protection and boot strap caught after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_r        <= 1'b0;
            act0_r        <= flash_prot_pkg::PROT_RST;
            act1_r        <= flash_prot_pkg::PROT_RST;
            download_mode <= 1'b0;
        end else if (!init_r) begin
            init_r        <= 1'b1;
            act0_r        <= nv_pend0_r;
            act1_r        <= nv_pend1_r;
            download_mode <= ~boot_select_pin;
        end
    end

    // access judgement for core, serial, debug and parallel routes
    always_comb begin
        if (!acc_array && acc_addr[15:flash_prot_pkg::GRP_LSB]
                == flash_prot_pkg::FW_GROUP) begin
            // firmware area hidden from all users
            acc_ok = 1'b0;
        end else if (acc_write) begin
            // same write check for every source
            acc_ok = wr_ok(acc_array, acc_addr);
        end else begin
            // read lock for debug and parallel
            acc_ok = eff0[flash_prot_pkg::READ_LOCK_BIT]
                     || (acc_src != flash_prot_pkg::SRC_DEBUG
                         && acc_src != flash_prot_pkg::SRC_PARALLEL);
        end
    end

    // one-cycle answer to each access request; requests before init denied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_grant <= 1'b0;
            acc_deny  <= 1'b0;
        end else begin
            acc_grant <= acc_req & init_r & acc_ok;
            acc_deny  <= acc_req & ~(init_r & acc_ok);
        end
    end

    chk_fw_denied: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_req && !acc_array && acc_addr[15:11] == 5'h1f
        |=> acc_deny && !acc_grant)
        else $error("firmware area access not denied");

    chk_page_erase_aligned: assert property (
        @(posedge pclk) disable iff (!presetn)
        arr_op && arr_kind == flash_prot_pkg::OP_PAGE
        |-> arr_addr[8:0] == 9'h000)
        else $error("erase not page aligned");

    chk_boot_strap: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(init_r) |-> download_mode == !$past(boot_select_pin))
        else $error("download mode does not follow strap");

    chk_debug_read_lock: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_req && !acc_write && acc_src == flash_prot_pkg::SRC_DEBUG
        && !eff0[31] |=> acc_deny)
        else $error("locked debug read granted");

    chk_grp0_write_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_req && acc_write && !acc_array && !eff0[acc_addr[15:11]]
        |=> acc_deny && !acc_grant)
        else $error("protected array 0 group write granted");

    chk_group_write_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_req && acc_write && acc_array && !eff1[acc_addr[15:11]]
        |=> acc_deny ##0 !acc_grant)
        else $error("protected group write granted");

    chk_volatile_now: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == flash_prot_pkg::OFS_VOL0
        |=> eff0 == ($past(pwdata) & act0_r))
        else $error("volatile protection not immediate");

    chk_save_pending: assert property (
        @(posedge pclk) disable iff (!presetn)
        do_save |=> act0_r == $past(act0_r)
        ##1 act0_r == $past(act0_r, 2))
        else $error("saved protection active before reset");

    chk_pending_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(init_r) |-> act0_r == $past(nv_pend0_r)
        && act1_r == $past(nv_pend1_r))
        else $error("pending protection not loaded at reset");

    chk_perm_refuse: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r == flash_prot_pkg::ST_CHECK
        && cmd_r == flash_prot_pkg::CMD_SAVE_KEY
        && nv_key_r == flash_prot_pkg::KEY_PERM
        |=> !res_ok_r ##1 sta_fail_r)
        else $error("permanent key save not refused");

    chk_wipe_key: assert property (
        @(posedge pclk) disable iff (!presetn)
        do_wipe |=> nv_key_r == flash_prot_pkg::KEY_ERASED
        && nv_pend0_r == flash_prot_pkg::PROT_RST)
        else $error("mass erase did not restore key");

    chk_status_read_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_sta && st_r != flash_prot_pkg::ST_FINISH
        |=> !sta_done_r && !sta_fail_r)
        else $error("status not cleared by read");
endmodule

// [tb/flash_array_model.sv]
// behavioural flash arrays behind the protection block
module flash_array_model (
    input  wire logic        pclk,
    input  wire logic        arr_op,
    input  wire logic [1:0]  arr_kind,
    input  wire logic        arr_sel,
    input  wire logic [15:0] arr_addr,
    input  wire logic [7:0]  arr_data,
    output logic      [7:0]  flash_cur_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:131071];
    initial mem = '{default: 8'hff};
    // byte under the address, looked at in the check cycle
    assign flash_cur_byte = mem[{arr_sel, arr_addr}];
    // programs only clear bits, erases act on whole pages
    always @(posedge pclk) begin
        if (arr_op && arr_kind == flash_prot_pkg::OP_PROGRAM)
            mem[{arr_sel, arr_addr}] <= mem[{arr_sel, arr_addr}] & arr_data;
        if (arr_op && arr_kind == flash_prot_pkg::OP_PAGE)
            for (int i = 0; i < 512; i++)
                mem[{arr_sel, arr_addr[15:9], i[8:0]}] <= 8'hff;
        if (arr_op && arr_kind == flash_prot_pkg::OP_MASS)
            for (int i = 0; i < 65536; i++)
                mem[{arr_sel, i[15:0]}] <= 8'hff;
    end
endmodule

// [tb/test_flash_protection_key_control.sv]
// self-checking bench for the flash protection key controller
module test_flash_protection_key_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, err;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, flash_cur_byte, arr_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, download_mode, acc_grant, acc_deny;
    logic        boot_select_pin = 1'h0, acc_req = 1'h0, acc_write = 1'h0;
    logic        acc_array = 1'h0, arr_op, arr_sel;
    logic [1:0]  acc_src = 2'h0, arr_kind;
    logic [15:0] acc_addr = 16'h0, arr_addr;
    int          errors = 0, n_checks = 0;
    // bench names match the ports one for one
    flash_protection_key_control DUT (.*);
    flash_array_model fm (.*);
    // 40 ns period
    always #20 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim(input logic hung);
        if (hung) begin
            errors++;
            $display("ERROR t=%0t wait limit reached", $time);
        end
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        repeat (16) if (pready !== 1'h1) @(posedge pclk);
        if (pready !== 1'h1) end_sim(1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask

    // one request; grant or deny is due one edge later
    task automatic acc(input logic w, input logic [1:0] s, input logic ar,
                       input logic [15:0] ad, input logic [1:0] exp);
        acc_req   <= 1'h1;
        acc_write <= w;
        acc_src   <= s;
        acc_array <= ar;
        acc_addr  <= ad;
        @(posedge pclk);
        acc_req <= 1'h0;
        @(posedge pclk);
        check({acc_grant, acc_deny}, exp);
    endtask

    // command, then status polled until done or fail shows
    task automatic cmd(input logic [7:0] c, input logic [1:0] exp);
        apb(1'h1, 8'h0c, {24'h0, c});
        rd = 32'h0;
        repeat (10) if (rd[1:0] === 2'h0) apb(1'h0, 8'h10, 32'h0);
        if (rd[1:0] === 2'h0) end_sim(1'h1);
        check(rd[1:0], exp);
        rdc(8'h10, 32'h0);
    endtask

    // system reset only; key store survives it
    task automatic do_reset(input logic strap);
        boot_select_pin <= strap;
        presetn         <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask

    // staged bits, key in addr and word, key enable, bit 5 low
    task automatic save(input logic [31:0] p, input logic [31:0] k,
                        input logic [1:0] exp);
        apb(1'h1, 8'h18, p);
        apb(1'h1, 8'h04, {16'h0, k[31:16]});
        apb(1'h1, 8'h08, {16'h0, k[15:0]});
        apb(1'h1, 8'h00, 32'h48);
        cmd(8'h0c, exp);
    endtask

    // volatile protection, read lock, hidden region, strap
    task automatic t_vol;
        check(download_mode, 1'h1);
        rdc(8'h14, flash_prot_pkg::PROT_RST);
        apb(1'h0, 8'h3c, 32'h0);
        check(err, 1'h1);
        apb(1'h1, 8'h14, 32'h7ffffffe);
        acc(1'h1, 2'h0, 1'h0, 16'h0000, 2'h1);
        acc(1'h1, 2'h0, 1'h0, 16'h0800, 2'h2);
        acc(1'h0, 2'h2, 1'h0, 16'h0800, 2'h1);
        acc(1'h0, 2'h3, 1'h1, 16'h0800, 2'h1);
        acc(1'h0, 2'h0, 1'h0, 16'hf800, 2'h1);
        apb(1'h1, 8'h14, 32'hffffffff);
        apb(1'h1, 8'h1c, 32'h7ffffffe);
        acc(1'h1, 2'h1, 1'h1, 16'hf800, 2'h1);
        acc(1'h1, 2'h2, 1'h1, 16'h07ff, 2'h1);
        acc(1'h0, 2'h2, 1'h1, 16'h0000, 2'h2);
        do_reset(1'h1);
        check(download_mode, 1'h0);
        acc(1'h1, 2'h1, 1'h1, 16'h0000, 2'h2);
        $display("test volatile done");
    endtask

    // program, page erase and the done interrupt
    task automatic t_prog;
        apb(1'h1, 8'h24, 32'h7);
        apb(1'h1, 8'h28, 32'h0);
        apb(1'h1, 8'h00, 32'h08);
        apb(1'h1, 8'h04, 32'h1000);
        apb(1'h1, 8'h08, 32'h5a);
        cmd(8'h02, 2'h1);
        check(fm.mem[17'h01000], 8'h5a);
        check(irq, 1'h0);
        apb(1'h1, 8'h28, 32'h1);
        @(posedge pclk);
        check(irq, 1'h1);
        apb(1'h1, 8'h24, 32'h1);
        @(posedge pclk);
        check(irq, 1'h0);
        apb(1'h1, 8'h08, 32'ha5);
        cmd(8'h02, 2'h2);
        // a cleared bit can only be set again by an erase
        cmd(8'h05, 2'h1);
        cmd(8'h02, 2'h1);
        check(fm.mem[17'h01000], 8'ha5);
        apb(1'h1, 8'h04, 32'hf800);
        cmd(8'h02, 2'h2);
        $display("test program done");
    endtask

    // persistent protection, key match, permanent key, mass erase
    task automatic t_key;
        save(32'hfffffffe, 32'h12345678, 2'h1);
        acc(1'h1, 2'h0, 1'h0, 16'h0000, 2'h2);
        do_reset(1'h1);
        acc(1'h1, 2'h0, 1'h0, 16'h0000, 2'h1);
        save(32'hffffffff, 32'h11111111, 2'h2);
        save(32'hfffffffd, 32'h12345678, 2'h1);
        // a stored key never changes, so the permanent key needs a wipe
        cmd(8'h06, 2'h1);
        save(32'hfffffffd, flash_prot_pkg::KEY_PERM, 2'h1);
        do_reset(1'h1);
        save(32'hffffffff, flash_prot_pkg::KEY_PERM, 2'h2);
        acc(1'h1, 2'h0, 1'h0, 16'h0800, 2'h1);
        apb(1'h1, 8'h00, 32'h08);
        apb(1'h1, 8'h04, 32'h0);
        cmd(8'h06, 2'h1);
        check(fm.mem[17'h01000], 8'hff);
        save(32'hffffffff, 32'h0000abcd, 2'h1);
        do_reset(1'h1);
        acc(1'h1, 2'h0, 1'h0, 16'h0800, 2'h2);
        $display("test key done");
    endtask

    // power-on: both resets low for two cycles
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        por_n   <= 1'h1;
        repeat (2) @(posedge pclk);
        t_vol();
        t_prog();
        t_key();
        end_sim(1'h0);
    end
endmodule
